// File: fcs_pkg.sv
`default_nettype none
package fcs_pkg;
  // ==========================================================
  // register map (APB byte offsets)
  localparam logic [11:0] FCS_CTRL_OFF   = 12'h000;
  localparam logic [11:0] FCS_ADDR_OFF   = 12'h004;
  localparam logic [11:0] FCS_DATA_OFF   = 12'h008;
  localparam logic [11:0] FCS_STAT_OFF   = 12'h00C;
  localparam logic [11:0] FCS_RDATA_OFF  = 12'h010;
  // ctrl command field, bits 3:0, writing starts the operation
  localparam int FCS_CMD_LSB  = 0;
  localparam int FCS_CMD_W    = 4;
  // status bit positions
  localparam int FCS_ST_BUSY  = 0;
  localparam int FCS_ST_DONE  = 1;
  localparam int FCS_ST_FAIL  = 2;
  localparam int FCS_ST_RYBY  = 3;
  localparam int FCS_ST_TIMEOUT = 4;
  // host commands
  localparam logic [3:0] FCS_OP_READ     = 4'h1;
  localparam logic [3:0] FCS_OP_PROGRAM  = 4'h2;
  localparam logic [3:0] FCS_OP_SECERASE = 4'h3;
  localparam logic [3:0] FCS_OP_CHIPERASE= 4'h4;
  localparam logic [3:0] FCS_OP_RESET    = 4'h5;
  localparam logic [3:0] FCS_OP_IDREAD   = 4'h6;
  localparam logic [3:0] FCS_OP_SUSPEND  = 4'h7;
  localparam logic [3:0] FCS_OP_RESUME   = 4'h8;
  localparam logic [3:0] FCS_OP_BYP_ENT  = 4'h9;
  localparam logic [3:0] FCS_OP_BYP_PROG = 4'hA;
  localparam logic [3:0] FCS_OP_BYP_RST  = 4'hB;
  localparam logic [3:0] FCS_OP_QUERY    = 4'hC;
  // flash command codes (word mode)
  localparam logic [10:0] FCS_UNLOCK1_A = 11'h555;
  localparam logic [10:0] FCS_UNLOCK2_A = 11'h2AA;
  localparam logic [10:0] FCS_QUERY_A   = 11'h055;
  localparam logic [7:0]  FCS_D_AA  = 8'hAA;
  localparam logic [7:0]  FCS_D_55  = 8'h55;
  localparam logic [7:0]  FCS_D_PRG = 8'hA0;
  localparam logic [7:0]  FCS_D_ERS = 8'h80;
  localparam logic [7:0]  FCS_D_CHP = 8'h10;
  localparam logic [7:0]  FCS_D_SEC = 8'h30;
  localparam logic [7:0]  FCS_D_ID  = 8'h90;
  localparam logic [7:0]  FCS_D_RST = 8'hF0;
  localparam logic [7:0]  FCS_D_SUS = 8'hB0;
  localparam logic [7:0]  FCS_D_RES = 8'h30;
  localparam logic [7:0]  FCS_D_BYP = 8'h20;
  localparam logic [7:0]  FCS_D_BRS = 8'h00;
  localparam logic [7:0]  FCS_D_QRY = 8'h98;
  // data bus status bits
  localparam int FCS_POLL_BIT = 7;
  localparam int FCS_TGL1_BIT = 6;
  localparam int FCS_FAIL_BIT = 5;
  localparam int FCS_WIN_BIT  = 3;
  localparam int FCS_TGL2_BIT = 2;
  // timing at 20 MHz
  localparam int FCS_CLK_MHZ      = 20;
  localparam int FCS_STROBE_NS    = 100;
  localparam int FCS_STROBE_CYC   = (FCS_STROBE_NS * FCS_CLK_MHZ + 999) / 1000;
  localparam int FCS_SETUP_NS     = 50;
  localparam int FCS_SETUP_CYC    = (FCS_SETUP_NS * FCS_CLK_MHZ + 999) / 1000;
  localparam int FCS_WINDOW_US    = 50;
  localparam int FCS_WINDOW_CYC   = FCS_WINDOW_US * FCS_CLK_MHZ;
  localparam int FCS_POLL_LIMIT   = 2000000;
  localparam int FCS_SEQ_MAX      = 6;
endpackage
`default_nettype wire

// File: fcs_strobe.sv
`timescale 1ns/1ps
`default_nettype none
// one flash bus cycle: setup, strobe low for a fixed count, release
module fcs_strobe
  import fcs_pkg::*;
#(
  parameter int LOW_CYC = FCS_STROBE_CYC,
  parameter int SET_CYC = FCS_SETUP_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic        is_write,
  output logic             busy,
  output logic             strobe_n,
  output logic             sample,
  output logic             done
);
  import fcs_pkg::*;
  typedef enum logic [1:0] {
    FCS_SB_IDLE = 2'b00,
    FCS_SB_SET  = 2'b01,
    FCS_SB_LOW  = 2'b10,
    FCS_SB_HOLD = 2'b11
  } fcs_sb_t;
  typedef struct packed {
    fcs_sb_t    st;
    logic [7:0] cnt;
    logic       wr;
  } fcs_sb_state_t;
  fcs_sb_state_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    unique case (s_reg.st)
      FCS_SB_IDLE: if (start) begin
        s_next.st  = FCS_SB_SET;
        s_next.cnt = 8'(SET_CYC);
        s_next.wr  = is_write;
      end
      FCS_SB_SET: if (s_reg.cnt <= 8'h01) begin
        s_next.st  = FCS_SB_LOW;
        s_next.cnt = 8'(LOW_CYC);
      end else begin
        s_next.cnt = s_reg.cnt - 8'h01;
      end
      FCS_SB_LOW: if (s_reg.cnt <= 8'h01) begin
        s_next.st  = FCS_SB_HOLD;
        s_next.cnt = 8'(SET_CYC);
      end else begin
        s_next.cnt = s_reg.cnt - 8'h01;
      end
      FCS_SB_HOLD: if (s_reg.cnt <= 8'h01) begin
        s_next.st = FCS_SB_IDLE;
      end else begin
        s_next.cnt = s_reg.cnt - 8'h01;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{st: FCS_SB_IDLE, cnt: 8'h00, wr: 1'b0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // strobe release separates reads so toggle bits advance
  assign strobe_n = (s_reg.st != FCS_SB_LOW);
  assign busy     = (s_reg.st != FCS_SB_IDLE);
  assign sample   = ce && (s_reg.st == FCS_SB_LOW) && (s_reg.cnt <= 8'h01) && !s_reg.wr;
  assign done     = ce && (s_reg.st == FCS_SB_HOLD) && (s_reg.cnt <= 8'h01);

  property p_strobe_width;
    @(posedge pclk) disable iff (!presetn)
      ($fell(strobe_n) && ce && LOW_CYC > 1) |=> !strobe_n;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe pulse too short");

  // ==========================================================
  // cycle shape: select, one setup cycle, two low cycles, one hold cycle
  sequence s_cycle_open;
    $rose(busy) && strobe_n;
  endsequence
  sequence s_pulse_low;
    (!strobe_n)[*2];
  endsequence
  property p_cycle_shape;
    @(posedge pclk) disable iff (!presetn || !ce)
      s_cycle_open |=> s_pulse_low ##1 (strobe_n && busy);
  endproperty
  a_cycle_shape: assert property (p_cycle_shape) else $error("flash cycle shape wrong");

  // select must still be low when the strobe rises, data latches there
  property p_release_framed;
    @(posedge pclk) disable iff (!presetn)
      $rose(strobe_n) |-> busy;
  endproperty
  a_release_framed: assert property (p_release_framed) else $error("select released with strobe");

  property p_done_ends;
    @(posedge pclk) disable iff (!presetn)
      done |=> !busy;
  endproperty
  a_done_ends: assert property (p_done_ends) else $error("cycle not closed after done");
endmodule
`default_nettype wire

// File: fcs_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pin inputs
module fcs_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fcs_sy_t;
  fcs_sy_t s_reg, s_next;
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end
  assign q = s_reg.s2;
endmodule
`default_nettype wire

// File: fcs_host.sv
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fcs_host
  import fcs_pkg::*;
#(
  parameter int POLL_LIMIT = FCS_POLL_LIMIT,
  parameter int AW         = 20
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic      [AW-1:0] flash_addr,
  output logic      [15:0]   flash_dq_out,
  output logic               flash_dq_oe,
  input  wire logic [15:0]   flash_dq_in,
  output logic               flash_ce_n,
  output logic               flash_oe_n,
  output logic               flash_we_n,
  input  wire logic          ready_busy_n
);
  import fcs_pkg::*;

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    FCS_IDLE  = 3'b000,
    FCS_ISSUE = 3'b001,
    FCS_WAIT  = 3'b010,
    FCS_POLL  = 3'b011,
    FCS_CHECK = 3'b100,
    FCS_FINAL = 3'b101
  } fcs_st_t;

  typedef struct packed {
    fcs_st_t      st;
    logic [3:0]   op;
    logic [2:0]   idx;
    logic [AW-1:0] addr;
    logic [15:0]  data;
    logic [15:0]  rdata;
    logic         busy;
    logic         done;
    logic         fail;
    logic         tmo;
    logic         bypass;
    logic         have_prev;
    logic         prev_t6;
    logic         fail_seen;
    logic [31:0]  wait_cnt;
    logic [31:0]  prdata;
  } fcs_host_t;

  fcs_host_t s_reg, s_next;
  logic        sb_busy, sb_strobe_n, sb_sample, sb_done, sb_start, sb_write;
  logic [15:0] dq_sync;
  logic        ryby_sync;
  logic [AW-1:0] cyc_addr;
  logic [15:0]   cyc_data;
  logic          cyc_write;
  logic [2:0]    seq_len;

  // ==========================================================
  // pin synchronisers and strobe engine
  fcs_sync #(.W(17)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (clk_en),
    .d       ({ready_busy_n, flash_dq_in}),
    .q       ({ryby_sync, dq_sync})
  );

  fcs_strobe u_strobe (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (clk_en),
    .start    (sb_start),
    .is_write (sb_write),
    .busy     (sb_busy),
    .strobe_n (sb_strobe_n),
    .sample   (sb_sample),
    .done     (sb_done)
  );

  // unlock pair used by the program, erase, ID read and bypass entry sequences
  function automatic logic [AW+16:0] unlock_cycle(input logic [2:0] i, input logic [7:0] cmd);
    logic [10:0] a;
    logic [7:0]  d;
    a = FCS_UNLOCK1_A;
    d = cmd;
    if (i == 3'd0) begin
      d = FCS_D_AA;
    end else if (i == 3'd1) begin
      a = FCS_UNLOCK2_A;
      d = FCS_D_55;
    end
    // high address bits left zero in command cycles
    unlock_cycle = {1'b1, AW'(a), 8'h00, d};
  endfunction

  // ==========================================================
  // sequence table: address, data, direction of cycle idx
  always_comb begin
    logic [AW+16:0] u;
    u         = unlock_cycle(s_reg.idx, FCS_D_PRG);
    cyc_addr  = u[AW+15:16];
    cyc_data  = u[15:0];
    cyc_write = 1'b1;
    seq_len   = 3'd1;
    // every cycle is a write except data reads and the ID code read
    unique case (s_reg.op)
      FCS_OP_READ: begin
        // plain read, no command cycles
        cyc_addr  = s_reg.addr;
        cyc_write = 1'b0;
      end
      FCS_OP_PROGRAM: begin
        seq_len = 3'd4;
        // program address and value in the last cycle
        if (s_reg.idx == 3'd3) begin
          cyc_addr = s_reg.addr;
          cyc_data = s_reg.data;
        end
      end
      FCS_OP_BYP_PROG: begin
        // two cycles honoured only in bypass mode
        seq_len  = 3'd2;
        cyc_addr = '0;
        cyc_data = {8'h00, FCS_D_PRG};
        if (s_reg.idx == 3'd1) begin
          cyc_addr = s_reg.addr;
          cyc_data = s_reg.data;
        end
      end
      FCS_OP_SECERASE, FCS_OP_CHIPERASE: begin
        seq_len = 3'd6; // one sector per sequence, the add window just runs out
        u = unlock_cycle(s_reg.idx == 3'd2 ? 3'd2 : (s_reg.idx > 3'd2 ? s_reg.idx - 3'd3 : s_reg.idx),
                         s_reg.idx == 3'd2 ? FCS_D_ERS : FCS_D_CHP);
        cyc_addr = u[AW+15:16];
        cyc_data = u[15:0];
        if (s_reg.idx == 3'd5 && s_reg.op == FCS_OP_SECERASE) begin
          // sector chosen by address bits 19..12
          cyc_addr = {s_reg.addr[AW-1:12], 12'h000};
          cyc_data = {8'h00, FCS_D_SEC};
        end
      end
      FCS_OP_IDREAD: begin
        // fourth cycle is a read of the code
        seq_len = 3'd4;
        u = unlock_cycle(s_reg.idx, FCS_D_ID);
        cyc_data = u[15:0];
        cyc_addr = u[AW+15:16];
        if (s_reg.idx == 3'd3) begin
          cyc_addr  = s_reg.addr;
          cyc_write = 1'b0;
        end
      end
      FCS_OP_RESET: begin
        // leaves identification mode and clears a failure
        cyc_addr = '0;
        cyc_data = {8'h00, FCS_D_RST};
      end
      FCS_OP_SUSPEND: begin
        cyc_addr = '0;
        cyc_data = {8'h00, FCS_D_SUS};
      end
      FCS_OP_RESUME: begin
        cyc_addr = '0;
        cyc_data = {8'h00, FCS_D_RES};
      end
      FCS_OP_BYP_ENT: begin
        seq_len = 3'd3;
        u = unlock_cycle(s_reg.idx, FCS_D_BYP);
        cyc_addr = u[AW+15:16];
        cyc_data = u[15:0];
      end
      FCS_OP_BYP_RST: begin
        // only way out of bypass
        seq_len  = 3'd2;
        cyc_addr = '0;
        cyc_data = {8'h00, (s_reg.idx == 3'd0) ? FCS_D_ID : FCS_D_BRS};
      end
      FCS_OP_QUERY: begin
        cyc_addr = AW'(FCS_QUERY_A);
        cyc_data = {8'h00, FCS_D_QRY};
      end
      default: begin
        seq_len = 3'd0;
      end
    endcase
  end

  // ==========================================================
  // main sequencer and APB slave
  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && !penable && !pwrite;
  wire is_algo = (s_reg.op == FCS_OP_PROGRAM) || (s_reg.op == FCS_OP_BYP_PROG) ||
                 (s_reg.op == FCS_OP_SECERASE) || (s_reg.op == FCS_OP_CHIPERASE);

  always_comb begin
    s_next   = s_reg;
    sb_start = 1'b0;
    sb_write = cyc_write;
    if (apb_rd) begin
      unique case (paddr)
        FCS_CTRL_OFF:  s_next.prdata = {28'h0, s_reg.op};
        FCS_ADDR_OFF:  s_next.prdata = 32'(s_reg.addr);
        FCS_DATA_OFF:  s_next.prdata = {16'h0, s_reg.data};
        FCS_STAT_OFF:  s_next.prdata = {27'h0, s_reg.tmo, ryby_sync, s_reg.fail, s_reg.done, s_reg.busy};
        FCS_RDATA_OFF: s_next.prdata = {16'h0, s_reg.rdata};
        default:       s_next.prdata = 32'h0;
      endcase
    end
    if (apb_wr && !s_reg.busy) begin
      unique case (paddr)
        FCS_ADDR_OFF: s_next.addr = pwdata[AW-1:0];
        FCS_DATA_OFF: s_next.data = pwdata[15:0];
        FCS_CTRL_OFF: begin
          s_next.op   = pwdata[FCS_CMD_LSB +: FCS_CMD_W];
          s_next.idx  = 3'd0;
          s_next.busy = 1'b1;
          s_next.done = 1'b0;
          s_next.fail = 1'b0;
          s_next.tmo  = 1'b0;
          s_next.st   = FCS_ISSUE;
        end
        default: ;
      endcase
    end
    unique case (s_reg.st)
      FCS_IDLE: ;
      FCS_ISSUE: begin
        if (seq_len == 3'd0 || (s_reg.op == FCS_OP_BYP_PROG && !s_reg.bypass)) begin
          s_next.fail = 1'b1;
          s_next.st   = FCS_FINAL;
        end else if (!sb_busy) begin
          sb_start  = 1'b1;
          s_next.st = FCS_WAIT;
        end
      end
      FCS_WAIT: begin
        if (sb_done && !cyc_write) begin // sync lags the pin two cycles, take data as the cycle closes
          s_next.rdata = dq_sync;
        end
        if (sb_done) begin
          if (s_reg.idx + 3'd1 < seq_len) begin
            s_next.idx = s_reg.idx + 3'd1;
            s_next.st  = FCS_ISSUE;
          end else if (is_algo) begin
            // status valid from last write strobe rise
            s_next.have_prev = 1'b0;
            s_next.fail_seen = 1'b0;
            s_next.wait_cnt  = 32'h0;
            s_next.st        = FCS_POLL;
          end else begin
            s_next.st = FCS_FINAL;
          end
        end
      end
      FCS_POLL: begin
        // repeated reads at program or sector address, at 555 for chip erase
        if (!sb_busy) begin
          sb_start = 1'b1;
          sb_write = 1'b0;
        end
        if (sb_sample) begin
          s_next.st = FCS_CHECK;
        end
        if (s_reg.wait_cnt >= 32'(POLL_LIMIT)) begin
          s_next.tmo = 1'b1;
          s_next.fail = 1'b1;
          s_next.st  = FCS_FINAL;
        end else begin
          s_next.wait_cnt = s_reg.wait_cnt + 32'h1;
        end
      end
      FCS_CHECK: begin
        // toggling bit 6 means still running
        s_next.have_prev = 1'b1;
        s_next.prev_t6   = dq_sync[FCS_TGL1_BIT];
        s_next.st        = FCS_POLL;
        if (s_reg.have_prev && dq_sync[FCS_TGL1_BIT] == s_reg.prev_t6) begin
          // stopped toggling; a later read gives settled data
          s_next.st = FCS_FINAL;
        end else if (s_reg.fail_seen) begin
          // still toggling after failure bit: operation failed
          s_next.fail = 1'b1;
          s_next.st   = FCS_FINAL;
        end else if (dq_sync[FCS_FAIL_BIT]) begin
          // recheck once more, toggling may stop as bit 5 rises
          s_next.fail_seen = 1'b1;
        end
      end
      FCS_FINAL: begin
        if (s_reg.op == FCS_OP_BYP_ENT) begin
          s_next.bypass = 1'b1;
        end
        if (s_reg.op == FCS_OP_BYP_RST || s_reg.op == FCS_OP_RESET) begin
          s_next.bypass = (s_reg.op == FCS_OP_RESET) ? s_reg.bypass : 1'b0;
        end
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        s_next.st   = FCS_IDLE;
      end
      default: s_next.st = FCS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign pready       = 1'b1;
  assign pslverr      = 1'b0;
  assign prdata       = s_reg.prdata;
  assign flash_addr   = cyc_addr;
  assign flash_dq_out = cyc_data;
  assign flash_dq_oe  = sb_busy && (s_reg.st == FCS_WAIT) && cyc_write;
  assign flash_ce_n   = !sb_busy;
  assign flash_we_n   = sb_strobe_n || !(s_reg.st == FCS_WAIT && cyc_write);
  assign flash_oe_n   = sb_strobe_n || (s_reg.st == FCS_WAIT && cyc_write);

  property p_one_strobe;
    @(posedge pclk) disable iff (!presetn)
      !(flash_we_n == 1'b0 && flash_oe_n == 1'b0);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("write and read strobe together");

  property p_done_clears_busy;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && s_reg.st == FCS_FINAL) |=> (!s_reg.busy && s_reg.done);
  endproperty
  a_done_clears_busy: assert property (p_done_clears_busy) else $error("busy not cleared");
endmodule
`default_nettype wire

// File: fcs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// behavioural flash device, word mode, timing in ns
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter int          PROG_NS    = 2000,
  parameter int          ERASE_NS   = 4000,
  parameter int          WIN_NS     = 3000,
  parameter logic [7:0]  PROT_SEC   = 8'h05,
  parameter logic [15:0] MAKER_CODE = 16'h005A, // arbitrary value
  parameter logic [15:0] DEV_CODE   = 16'h1357, // arbitrary value
  parameter logic [15:0] QUERY_CODE = 16'h0051
) (
  input  wire logic [19:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [15:0] dq_drv,
  output logic      [15:0] dq,
  output logic             ready_busy_n
);
  logic [15:0]  mem [int];
  logic [255:0] sel = '0;
  logic [19:0]  la, pa;
  logic [15:0]  pd, last = 16'h0000;
  logic         busy = 0, ers = 0, susp = 0, tgl1 = 0, tgl2 = 0, wact = 0, pgood = 0, lim = 0;
  int           step = 0, mode = 0, rem = 0;
  function automatic logic [15:0] rd(int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  function automatic logic [15:0] outv(logic [19:0] a);
    if (busy && !susp && ers) return {8'h00, 1'b0, tgl1, 2'b00, rem <= ERASE_NS, sel[a[19:12]] & tgl2, 2'b00};
    if (busy && !susp) return {8'h00, ~pd[7], tgl1, lim, 5'h00};
    if (susp && sel[a[19:12]]) return {8'h00, 1'b1, tgl1, 3'b000, tgl2, 2'b00};
    if (mode == 1) return a[1:0] == 2'h2 ? {15'h0000, a[19:12] == PROT_SEC} : (a[0] ? DEV_CODE : MAKER_CODE);
    if (mode == 2) return QUERY_CODE;
    return rd(a);
  endfunction
  task automatic erase(logic [7:0] s, logic all);
    sel = all ? '1 : (256'h1 << s);
    sel[PROT_SEC] = 1'b0;
    rem = all ? ERASE_NS : WIN_NS + ERASE_NS;
    busy = 1;
    ers = 1;
  endtask
  task automatic cmd(logic [19:0] a, logic [15:0] w);
    logic [10:0] c;
    logic [7:0]  d;
    c = a[10:0];
    d = w[7:0];
    if (busy && !susp) begin
      if (lim && d == FCS_D_RST) {busy, lim} = 2'b00;
      if (ers && d == FCS_D_SUS) susp = 1;
      return;
    end
    if (d == FCS_D_RST && mode != 3) begin
      mode = 0;
      step = 0;
      return;
    end
    if (susp && step == 0 && d == FCS_D_RES) begin
      susp = 0;
      return;
    end
    case (step)
      0: if (mode == 3) step = d == FCS_D_PRG ? 3 : (d == FCS_D_ID ? 10 : 0);
         else if (c == FCS_QUERY_A && d == FCS_D_QRY && mode < 2 && !susp) mode = 2;
         else step = (c == FCS_UNLOCK1_A && d == FCS_D_AA) ? 1 : 0;
      1: step = (c == FCS_UNLOCK2_A && d == FCS_D_55) ? 2 : 0;
      2: begin
        step = 0;
        if (c == FCS_UNLOCK1_A && d == FCS_D_ID) mode = 1;
        if (c == FCS_UNLOCK1_A && !susp && mode == 0) begin
          if (d == FCS_D_PRG) step = 3;
          if (d == FCS_D_ERS) step = 4;
          if (d == FCS_D_BYP) mode = 3;
        end
      end
      3: begin
        step = 0;
        pa = a;
        pd = w;
        pgood = a[19:12] != PROT_SEC;
        lim = (w & ~rd(a)) != 16'h0000; // a 0 cannot go back to 1: stall with fail bit
        busy = 1;
        ers = 0;
        rem = PROG_NS;
      end
      4: step = (c == FCS_UNLOCK1_A && d == FCS_D_AA) ? 5 : 0;
      5: step = (c == FCS_UNLOCK2_A && d == FCS_D_55) ? 6 : 0;
      6: begin
        step = 0;
        if (d == FCS_D_CHP) erase(8'h00, 1'b1);
        if (d == FCS_D_SEC) erase(a[19:12], 1'b0);
      end
      10: begin
        step = 0;
        if (d == FCS_D_BRS) mode = 0;
      end
      default: step = 0;
    endcase
  endtask
  // address on the later falling strobe, data on the earlier rising one
  always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) begin
    la = addr;
    wact = 1;
  end
  always @(posedge we_n or posedge ce_n) if (wact) begin
    wact = 0;
    cmd(la, dq_drv);
  end
  always @(negedge oe_n or negedge ce_n) if (!oe_n && !ce_n) begin
    if (busy && !susp) tgl1 = ~tgl1;
    if (ers) tgl2 = ~tgl2;
  end
  always begin
    #100;
    if (busy && !susp && !lim) begin
      rem -= 100;
      if (rem <= 0) begin
        int ks[$];
        if (ers) foreach (mem[k]) if (sel[k >> 12]) ks.push_back(k);
        foreach (ks[i]) mem.delete(ks[i]);
        if (!ers && pgood) mem[pa] = rd(pa) & pd;
        busy = 0;
        ers = 0;
        sel = '0;
      end
    end
  end
  // released bus shows the inverse of the last value, no pull-up on dq
  always begin
    #5;
    if (!ce_n && !oe_n) begin
      dq = outv(addr);
      last = dq;
    end else dq = ~last;
  end
  assign ready_busy_n = (busy && !susp) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: test_flash_command_status_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_command_status_logic;
  import fcs_pkg::*;
  localparam logic [7:0] PROT = 8'h05;
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h339DF0BF;
  logic        pready, pslverr, dq_oe, ce_n, oe_n, we_n, rybn;
  logic [19:0] fa;
  logic [15:0] dq_o, dq_i;
  logic [15:0] exp_mem [int];
  int          used [$];
  int          num_errors = 0, compares = 0, cyc = 0;
  always #25 pclk = ~pclk;
  fcs_host #(.POLL_LIMIT(2000)) fcs_host_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_addr(fa), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe), .flash_dq_in(dq_i),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .ready_busy_n(rybn));
  fcs_flash_model #(.PROT_SEC(PROT)) fcs_flash_model_i (.addr(fa), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .dq_drv(dq_oe ? dq_o : ~dq_o), .dq(dq_i), .ready_busy_n(rybn));
  task automatic end_sim();
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] em(int a);
    return exp_mem.exists(a) ? exp_mem[a] : 16'hFFFF;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    chk({15'h0000, pslverr}, 16'h0000);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d, output logic [31:0] st);
    logic [31:0] r;
    int          n;
    apb(1'b1, FCS_ADDR_OFF, {12'h000, a}, r);
    apb(1'b1, FCS_DATA_OFF, {16'h0000, d}, r);
    apb(1'b1, FCS_CTRL_OFF, {28'h0000000, c}, r);
    n = 0;
    do begin
      apb(1'b0, FCS_STAT_OFF, 32'h0, st);
      n++;
    end while (st[FCS_ST_BUSY] !== 1'b0 && n < 2000);
    chk({14'h0000, st[FCS_ST_BUSY], st[FCS_ST_TIMEOUT]}, 16'h0000);
  endtask
  task automatic rdchk(input logic [19:0] a);
    logic [31:0] st, r;
    op(FCS_OP_READ, a, 16'h0000, st);
    apb(1'b0, FCS_RDATA_OFF, 32'h0, r);
    chk(r[15:0], em(a));
  endtask
  task automatic prog(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d);
    logic [31:0] st;
    op(c, a, d, st);
    chk({15'h0000, st[FCS_ST_RYBY]}, 16'h0001);
    if (a[19:12] != PROT) exp_mem[a] = em(a) & d;
    used.push_back(a);
    rdchk(a);
  endtask
  task automatic idchk(input logic [7:0] s, input logic [15:0] e);
    logic [31:0] st, r;
    op(FCS_OP_IDREAD, {s, 12'h002}, 16'h0000, st);
    apb(1'b0, FCS_RDATA_OFF, 32'h0, r);
    chk({8'h00, r[7:0]}, e);
    op(FCS_OP_RESET, 20'h00000, 16'h0000, st);
  endtask
  initial begin
    logic [31:0] st;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, FCS_STAT_OFF, 32'h0, st);
    chk({15'h0000, st[FCS_ST_BUSY]}, 16'h0000);
    rdchk(20'h01234);
    for (int i = 0; i < 8; i++) prog(FCS_OP_PROGRAM, {8'(1 + i % 3), 12'(xs())}, 16'(xs()));
    prog(FCS_OP_PROGRAM, {PROT, 12'h010}, 16'h0000);
    op(FCS_OP_BYP_PROG, 20'h02100, 16'h1234, st);
    chk({15'h0000, st[FCS_ST_FAIL]}, 16'h0001);
    op(FCS_OP_BYP_ENT, 20'h00000, 16'h0000, st);
    for (int i = 0; i < 2; i++) prog(FCS_OP_BYP_PROG, {8'h02, 12'(xs())}, 16'(xs()));
    op(FCS_OP_BYP_RST, 20'h00000, 16'h0000, st);
    prog(FCS_OP_PROGRAM, {8'h03, 12'(xs())}, 16'(xs()));
    idchk(PROT, 16'h0001);
    idchk(8'h02, 16'h0000);
    rdchk(used[0]);
    op(FCS_OP_QUERY, 20'h00000, 16'h0000, st);
    op(FCS_OP_RESET, 20'h00000, 16'h0000, st);
    rdchk(used[1]);
    op(FCS_OP_SUSPEND, 20'h00000, 16'h0000, st);
    op(FCS_OP_RESUME, 20'h00000, 16'h0000, st);
    rdchk(used[2]);
    prog(FCS_OP_PROGRAM, 20'h04F00, 16'h0000);
    op(FCS_OP_PROGRAM, 20'h04F00, 16'hFFFF, st);
    chk({15'h0000, st[FCS_ST_FAIL]}, 16'h0001);
    op(FCS_OP_RESET, 20'h00000, 16'h0000, st);
    rdchk(20'h04F00);
    op(FCS_OP_SECERASE, 20'h01000, 16'h0000, st);
    foreach (used[i]) if ((used[i] >> 12) == 1) exp_mem.delete(used[i]);
    foreach (used[i]) rdchk(used[i]);
    op(FCS_OP_CHIPERASE, 20'h00000, 16'h0000, st);
    exp_mem.delete();
    foreach (used[i]) rdchk(used[i]);
    end_sim();
  end
endmodule
`default_nettype wire
